//--- rtcsl_consts.svh
`ifndef RTCSL_CONSTS_SVH
`define RTCSL_CONSTS_SVH

// register byte offsets
`define RTCSL_OFS_SECONDS        8'h00
`define RTCSL_OFS_PRESCALER      8'h04
`define RTCSL_OFS_ALARM          8'h08
`define RTCSL_OFS_COMPENSATION   8'h0C
`define RTCSL_OFS_CONTROL        8'h10
`define RTCSL_OFS_STATUS         8'h14
`define RTCSL_OFS_LOCK           8'h18

// clock_status fields
`define RTCSL_SR_COUNTER_ENABLE  4
`define RTCSL_SR_ALARM_FLAG      2
`define RTCSL_SR_OVERFLOW_FLAG   1
`define RTCSL_SR_INVALID_FLAG    0

// clock_write_lock fields
`define RTCSL_LR_SELF_LOCK       6
`define RTCSL_LR_STATUS_LOCK     5
`define RTCSL_LR_CONTROL_LOCK    4
`define RTCSL_LR_COMP_LOCK       3
`define RTCSL_LR_FIXED_ONES      32'h0000_0087

// control fields
`define RTCSL_CR_UPDATE_MODE     3
`define RTCSL_CR_SOFT_RESET      0

// reset values
`define RTCSL_RST_WORD           32'h0000_0000
`define RTCSL_RST_FLAG_CLEAR     1'h0
`define RTCSL_RST_INVALID        1'h1
`define RTCSL_RST_LOCK_OPEN      1'h1

`endif

//--- rtcsl_pkg.sv
package rtcsl_pkg;

  typedef logic [31:0] rtcsl_word_t;
  typedef logic [3:0]  rtcsl_be_t;
  typedef logic [7:0]  rtcsl_addr_t;

endpackage : rtcsl_pkg

//--- rtcsl_status_lock.sv
// Operation
// - counter disabled: seconds and prescaler writable, both hold still
// - counter enabled: seconds and prescaler writes ignored, both may count
// - alarm flag sets when alarm equals seconds as seconds increments
// - a write to the alarm compare register clears the alarm flag, unless an alarm match sets it in the same cycle
// - seconds wrap past maximum while enabled sets the overflow flag
// - overflow set: counting stops, seconds and prescaler read zero
// - seconds write while disabled clears overflow and invalid-time flags
// - invalid-time flag sets on power-on reset and on software reset
// - invalid-time set: counting stops, seconds and prescaler read zero
// - self-lock clear ignores lock writes; only resets set it again
// - status-lock clear ignores status writes; only resets set it again
// - control-lock clear ignores control writes; only power-on restores
// - compensation-lock clear ignores compensation writes; resets restore
// - update mode lets enable be written under status lock, limited cases
// - software reset bit resets the block; cleared by power-on or write 0
// - prescaler steps per oscillator cycle when enabled and overflow and invalid-time flags clear
// - seconds step on each falling edge of prescaler bit 14
`timescale 1ns/1ps
`include "rtcsl_consts.svh"

module rtcsl_status_lock
  import rtcsl_pkg::*;
#(
  parameter int PRESC_W = 16,
  parameter int SEC_TAP = 14
) (
  input  wire logic        clock_in,
  input  wire logic        nrst_in,
  input  wire logic        osc_clk_in,
  input  wire rtcsl_addr_t avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire rtcsl_word_t avs_writedata_in,
  input  wire rtcsl_be_t   avs_byteenable_in,
  output rtcsl_word_t      avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic             alarm_flag_out,
  output logic             overflow_flag_out,
  output logic             invalid_time_flag_out
);

  generate
    if (PRESC_W < 2 || PRESC_W > 32 || SEC_TAP >= PRESC_W || SEC_TAP < 0)
    begin : g_bad_param
      $error("rtcsl_status_lock: prescaler width or tap out of range");
    end
  endgenerate

  function automatic rtcsl_word_t be_mask(input rtcsl_be_t be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  function automatic rtcsl_word_t merge(input rtcsl_word_t old_val,
                                        input rtcsl_word_t new_val,
                                        input rtcsl_word_t mask);
    return (old_val & ~mask) | (new_val & mask);
  endfunction : merge

  // bus handshake: one wait state per access
  logic              ack_ff;
  logic              req;
  logic              wr_fire;
  logic              rd_load;
  rtcsl_word_t       wmask;
  rtcsl_word_t       wdata;
  rtcsl_word_t       rd_value;
  rtcsl_word_t       readdata_ff;

  // register state
  rtcsl_word_t       seconds_ff;
  logic [PRESC_W-1:0] presc_ff;
  rtcsl_word_t       alarm_ff;
  rtcsl_word_t       comp_ff;
  logic              counter_enable_ff;
  logic              alarm_flag_ff;
  logic              overflow_flag_ff;
  logic              invalid_time_flag_ff;
  logic              lock_self_lock_ff;
  logic              status_lock_ff;
  logic              control_lock_ff;
  logic              compensation_lock_ff;
  logic              update_mode_ff;
  logic              software_reset_bit_ff;

  // oscillator synchroniser
  logic              osc_meta_ff;
  logic              osc_sync_ff;
  logic              osc_prev_ff;
  logic              osc_rise;

  // counting
  logic              count_allowed;
  logic              presc_step;
  logic [PRESC_W-1:0] nxt_presc;
  rtcsl_word_t       presc_wr_val;
  logic              sec_step;
  logic              sec_wrap;
  logic              time_blanked;
  logic              soft_rst;

  // decoded writes
  logic              wr_seconds;
  logic              wr_presc;
  logic              wr_alarm;
  logic              wr_comp;
  logic              wr_control;
  logic              wr_status;
  logic              wr_lock;
  logic              time_wr_ok;
  logic              sec_wr_ok;
  logic              enable_wr_ok;

  assign req                 = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_ff;
  assign wr_fire             = avs_write_in & ack_ff;
  assign rd_load             = avs_read_in & ~ack_ff;
  assign wmask               = be_mask(avs_byteenable_in);
  assign wdata               = avs_writedata_in;
  assign avs_readdata_out    = readdata_ff;

  assign alarm_flag_out        = alarm_flag_ff;
  assign overflow_flag_out     = overflow_flag_ff;
  assign invalid_time_flag_out = invalid_time_flag_ff;

  // held while the bit stays set, so the block is kept in reset
  assign soft_rst = software_reset_bit_ff;

  assign wr_seconds = wr_fire & (avs_address_in == `RTCSL_OFS_SECONDS);
  assign wr_presc   = wr_fire & (avs_address_in == `RTCSL_OFS_PRESCALER);
  assign wr_alarm   = wr_fire & (avs_address_in == `RTCSL_OFS_ALARM);
  assign wr_comp    = wr_fire & (avs_address_in == `RTCSL_OFS_COMPENSATION);
  assign wr_control = wr_fire & (avs_address_in == `RTCSL_OFS_CONTROL);
  assign wr_status  = wr_fire & (avs_address_in == `RTCSL_OFS_STATUS);
  assign wr_lock    = wr_fire & (avs_address_in == `RTCSL_OFS_LOCK);

  assign time_wr_ok = ~counter_enable_ff;
  assign sec_wr_ok  = wr_seconds & time_wr_ok;

  // status lock bypass for the enable bit alone
  assign enable_wr_ok = wr_status & wmask[`RTCSL_SR_COUNTER_ENABLE] &
                        (status_lock_ff |
                         (update_mode_ff & (overflow_flag_ff |
                          invalid_time_flag_ff | ~counter_enable_ff)));

  assign osc_rise      = osc_sync_ff & ~osc_prev_ff;
  assign count_allowed = counter_enable_ff & ~overflow_flag_ff &
                         ~invalid_time_flag_ff;
  assign presc_step    = count_allowed & osc_rise;
  assign nxt_presc     = presc_ff + {{(PRESC_W-1){1'b0}}, 1'b1};
  assign presc_wr_val  = merge({{(32-PRESC_W){1'b0}}, presc_ff}, wdata,
                               wmask);
  assign sec_step      = presc_step & presc_ff[SEC_TAP] &
                         ~nxt_presc[SEC_TAP];
  assign sec_wrap      = sec_step & (&seconds_ff);
  assign time_blanked  = overflow_flag_ff | invalid_time_flag_ff;

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // oscillator pin crosses in; not touched by software reset
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      osc_meta_ff <= 1'b0;
      osc_sync_ff <= 1'b0;
      osc_prev_ff <= 1'b0;
    end else begin
      osc_meta_ff <= osc_clk_in;
      osc_sync_ff <= osc_meta_ff;
      osc_prev_ff <= osc_sync_ff;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      seconds_ff <= `RTCSL_RST_WORD;
    end else if (soft_rst) begin
      seconds_ff <= `RTCSL_RST_WORD;
    end else if (sec_wr_ok) begin
      seconds_ff <= merge(seconds_ff, wdata, wmask);
    end else if (sec_step) begin
      // wraps to zero; overflow flag then freezes it
      seconds_ff <= seconds_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      presc_ff <= '0;
    end else if (soft_rst) begin
      presc_ff <= '0;
    end else if (wr_presc & time_wr_ok) begin
      presc_ff <= presc_wr_val[PRESC_W-1:0];
    end else if (presc_step) begin
      presc_ff <= nxt_presc;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      alarm_ff <= `RTCSL_RST_WORD;
    end else if (soft_rst) begin
      alarm_ff <= `RTCSL_RST_WORD;
    end else if (wr_alarm) begin
      alarm_ff <= merge(alarm_ff, wdata, wmask);
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      comp_ff <= `RTCSL_RST_WORD;
    end else if (soft_rst) begin
      comp_ff <= `RTCSL_RST_WORD;
    end else if (wr_comp & compensation_lock_ff) begin
      comp_ff <= merge(comp_ff, wdata, wmask);
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      counter_enable_ff <= `RTCSL_RST_FLAG_CLEAR;
    end else if (soft_rst) begin
      counter_enable_ff <= `RTCSL_RST_FLAG_CLEAR;
    end else if (enable_wr_ok) begin
      counter_enable_ff <= wdata[`RTCSL_SR_COUNTER_ENABLE];
    end
  end

  // set beats the clear of a same-cycle alarm write
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      alarm_flag_ff <= `RTCSL_RST_FLAG_CLEAR;
    end else if (soft_rst) begin
      alarm_flag_ff <= `RTCSL_RST_FLAG_CLEAR;
    end else if (sec_step && (alarm_ff == seconds_ff)) begin
      alarm_flag_ff <= 1'b1;
    end else if (wr_alarm) begin
      alarm_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      overflow_flag_ff <= `RTCSL_RST_FLAG_CLEAR;
    end else if (soft_rst) begin
      overflow_flag_ff <= `RTCSL_RST_FLAG_CLEAR;
    end else if (sec_wrap) begin
      overflow_flag_ff <= 1'b1;
    end else if (sec_wr_ok) begin
      overflow_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      invalid_time_flag_ff <= `RTCSL_RST_INVALID;
    end else if (soft_rst) begin
      invalid_time_flag_ff <= `RTCSL_RST_INVALID;
    end else if (sec_wr_ok) begin
      invalid_time_flag_ff <= 1'b0;
    end
  end

  // lock bits can only be cleared by software
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lock_self_lock_ff    <= `RTCSL_RST_LOCK_OPEN;
      status_lock_ff       <= `RTCSL_RST_LOCK_OPEN;
      compensation_lock_ff <= `RTCSL_RST_LOCK_OPEN;
    end else if (soft_rst) begin
      lock_self_lock_ff    <= `RTCSL_RST_LOCK_OPEN;
      status_lock_ff       <= `RTCSL_RST_LOCK_OPEN;
      compensation_lock_ff <= `RTCSL_RST_LOCK_OPEN;
    end else if (wr_lock & lock_self_lock_ff) begin
      lock_self_lock_ff    <= lock_self_lock_ff &
                              (wdata[`RTCSL_LR_SELF_LOCK] |
                               ~wmask[`RTCSL_LR_SELF_LOCK]);
      status_lock_ff       <= status_lock_ff &
                              (wdata[`RTCSL_LR_STATUS_LOCK] |
                               ~wmask[`RTCSL_LR_STATUS_LOCK]);
      compensation_lock_ff <= compensation_lock_ff &
                              (wdata[`RTCSL_LR_COMP_LOCK] |
                               ~wmask[`RTCSL_LR_COMP_LOCK]);
    end
  end

  // untouched by software reset; only power-on reopens the control register
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      control_lock_ff <= `RTCSL_RST_LOCK_OPEN;
    end else if (wr_lock & lock_self_lock_ff) begin
      control_lock_ff <= control_lock_ff &
                         (wdata[`RTCSL_LR_CONTROL_LOCK] |
                          ~wmask[`RTCSL_LR_CONTROL_LOCK]);
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      update_mode_ff <= `RTCSL_RST_FLAG_CLEAR;
    end else if (soft_rst) begin
      update_mode_ff <= `RTCSL_RST_FLAG_CLEAR;
    end else if (wr_control & control_lock_ff &
                 wmask[`RTCSL_CR_UPDATE_MODE]) begin
      update_mode_ff <= wdata[`RTCSL_CR_UPDATE_MODE];
    end
  end

  // the reset bit itself is exempt from its own reset
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      software_reset_bit_ff <= `RTCSL_RST_FLAG_CLEAR;
    end else if (wr_control & control_lock_ff &
                 wmask[`RTCSL_CR_SOFT_RESET]) begin
      software_reset_bit_ff <= wdata[`RTCSL_CR_SOFT_RESET];
    end
  end

  // unmapped offsets read zero and take no write
  always_comb begin
    rd_value = `RTCSL_RST_WORD;
    unique case (avs_address_in)
      `RTCSL_OFS_SECONDS: begin
        rd_value = time_blanked ? `RTCSL_RST_WORD : seconds_ff;
      end
      `RTCSL_OFS_PRESCALER: begin
        rd_value = time_blanked ? `RTCSL_RST_WORD :
                   {{(32-PRESC_W){1'b0}}, presc_ff};
      end
      `RTCSL_OFS_ALARM: begin
        rd_value = alarm_ff;
      end
      `RTCSL_OFS_COMPENSATION: begin
        rd_value = comp_ff;
      end
      `RTCSL_OFS_CONTROL: begin
        rd_value[`RTCSL_CR_UPDATE_MODE] = update_mode_ff;
        rd_value[`RTCSL_CR_SOFT_RESET]  = software_reset_bit_ff;
      end
      `RTCSL_OFS_STATUS: begin
        rd_value[`RTCSL_SR_COUNTER_ENABLE] = counter_enable_ff;
        rd_value[`RTCSL_SR_ALARM_FLAG]     = alarm_flag_ff;
        rd_value[`RTCSL_SR_OVERFLOW_FLAG]  = overflow_flag_ff;
        rd_value[`RTCSL_SR_INVALID_FLAG]   = invalid_time_flag_ff;
      end
      `RTCSL_OFS_LOCK: begin
        rd_value = `RTCSL_LR_FIXED_ONES;
        rd_value[`RTCSL_LR_SELF_LOCK]    = lock_self_lock_ff;
        rd_value[`RTCSL_LR_STATUS_LOCK]  = status_lock_ff;
        rd_value[`RTCSL_LR_CONTROL_LOCK] = control_lock_ff;
        rd_value[`RTCSL_LR_COMP_LOCK]    = compensation_lock_ff;
      end
      default: begin
        rd_value = `RTCSL_RST_WORD;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      readdata_ff <= `RTCSL_RST_WORD;
    end else if (rd_load) begin
      readdata_ff <= rd_value;
    end
  end

endmodule : rtcsl_status_lock

//--- rtcsl_status_lock_props.sv
`timescale 1ns/1ps
module rtcsl_status_lock_chk
  import rtcsl_pkg::*;
(
  input wire logic        clock_in,
  input wire logic        nrst_in,
  input wire rtcsl_addr_t avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire rtcsl_word_t avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        alarm_flag_out,
  input wire logic        overflow_flag_out,
  input wire logic        invalid_time_flag_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  // transfer completes at the edge where waitrequest is seen low
  wire rd_at  = avs_read_in && !avs_waitrequest_out;
  wire wr_at  = avs_write_in && !avs_waitrequest_out;
  wire sec_wr = wr_at && avs_address_in == 8'h00;
  wire tm_rd  = rd_at && avs_address_in[7:3] == 5'h00;

  one_wait_a: assert property ((avs_read_in || avs_write_in)
    && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("request not answered after one wait state");
  idle_nowait_a: assert property (!(avs_read_in || avs_write_in)
    |-> !avs_waitrequest_out) else $error("waitrequest while idle");
  por_flags_a: assert property ($rose(nrst_in) |-> invalid_time_flag_out
    && !overflow_flag_out && !alarm_flag_out)
    else $error("flags wrong after power-on reset");
  alarm_clear_a: assert property (wr_at && avs_address_in == 8'h08
    |=> !alarm_flag_out) else $error("alarm write left flag set");
  ovf_clear_a: assert property ($fell(overflow_flag_out)
    |-> $past(sec_wr) || invalid_time_flag_out)
    else $error("overflow cleared without seconds write");
  inv_clear_a: assert property ($fell(invalid_time_flag_out)
    |-> $past(sec_wr)) else $error("invalid cleared without seconds write");
  ovf_rise_a: assert property ($rose(overflow_flag_out)
    |-> !$past(invalid_time_flag_out))
    else $error("overflow set while time invalid");
  zero_read_a: assert property (tm_rd && ($past(overflow_flag_out)
    || $past(invalid_time_flag_out)) |-> avs_readdata_out == 32'h0)
    else $error("time read not zero while flagged");
  status_bits_a: assert property (rd_at && avs_address_in == 8'h14
    |-> avs_readdata_out[31:5] == 27'h0 && !avs_readdata_out[3]
    && avs_readdata_out[2:0] == {$past(alarm_flag_out),
    $past(overflow_flag_out), $past(invalid_time_flag_out)})
    else $error("status read inconsistent");
  lock_fixed_a: assert property (rd_at && avs_address_in == 8'h18
    |-> avs_readdata_out[31:8] == 24'h0 && avs_readdata_out[7]
    && avs_readdata_out[2:0] == 3'h7) else $error("lock fixed bits wrong");
  unmapped_zero_a: assert property (rd_at && avs_address_in >= 8'h1C
    |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
endmodule : rtcsl_status_lock_chk

bind rtcsl_status_lock rtcsl_status_lock_chk rtcsl_status_lock_chk_i (
  .clock_in              (clock_in),
  .nrst_in               (nrst_in),
  .avs_address_in        (avs_address_in),
  .avs_read_in           (avs_read_in),
  .avs_write_in          (avs_write_in),
  .avs_readdata_out      (avs_readdata_out),
  .avs_waitrequest_out   (avs_waitrequest_out),
  .alarm_flag_out        (alarm_flag_out),
  .overflow_flag_out     (overflow_flag_out),
  .invalid_time_flag_out (invalid_time_flag_out)
);

//--- test_rtcsl_status_lock.sv
`timescale 1ns/1ps
module test_rtcsl_status_lock;
  import rtcsl_pkg::*;
  logic        clock_in          = 1'b0;
  logic        nrst_in           = 1'b0;
  logic        osc_clk_in        = 1'b0;
  rtcsl_addr_t avs_address_in    = 8'h00;
  logic        avs_read_in       = 1'b0;
  logic        avs_write_in      = 1'b0;
  rtcsl_word_t avs_writedata_in  = 32'h0;
  rtcsl_be_t   avs_byteenable_in = 4'hF;
  rtcsl_word_t avs_readdata_out;
  logic        avs_waitrequest_out;
  logic        alarm_flag_out;
  logic        overflow_flag_out;
  logic        invalid_time_flag_out;
  int          fails   = 0;
  int          n_tests = 0;

  // short prescaler: one second is eight oscillator cycles
  rtcsl_status_lock #(.PRESC_W(4), .SEC_TAP(2)) rtcsl_status_lock_i (
    .clock_in              (clock_in),
    .nrst_in               (nrst_in),
    .osc_clk_in            (osc_clk_in),
    .avs_address_in        (avs_address_in),
    .avs_read_in           (avs_read_in),
    .avs_write_in          (avs_write_in),
    .avs_writedata_in      (avs_writedata_in),
    .avs_byteenable_in     (avs_byteenable_in),
    .avs_readdata_out      (avs_readdata_out),
    .avs_waitrequest_out   (avs_waitrequest_out),
    .alarm_flag_out        (alarm_flag_out),
    .overflow_flag_out     (overflow_flag_out),
    .invalid_time_flag_out (invalid_time_flag_out)
  );

  always #50 clock_in = ~clock_in;
  always begin
    repeat (4) @(posedge clock_in);
    osc_clk_in <= ~osc_clk_in;
  end

  task chk(input string what, input rtcsl_word_t seen, input rtcsl_word_t exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // outputs are sampled at the falling edge: they are settled there and
  // equal to what the next rising edge sees
  task xfer(input logic w, input rtcsl_addr_t a, input rtcsl_word_t d,
            output rtcsl_word_t q);
    int   n;
    logic ok;
    n = 0;
    ok = 1'b0;
    @(posedge clock_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    while (!ok) begin
      @(negedge clock_in);
      ok = (avs_waitrequest_out === 1'b0);
      q = avs_readdata_out;
      if (n++ > 50) begin
        fails++;
        stop_test();
      end
      @(posedge clock_in);
    end
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask : xfer

  task wr(input rtcsl_addr_t a, input rtcsl_word_t d);
    rtcsl_word_t q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task rd(input rtcsl_addr_t a, input rtcsl_word_t exp);
    rtcsl_word_t q;
    xfer(1'b0, a, 32'h0, q);
    chk($sformatf("reg_%h", a), q, exp);
  endtask : rd

  task wait_hi(input bit ovf);
    int   n;
    logic f;
    n = 0;
    f = 1'b0;
    while (f !== 1'b1 && n < 3000) begin
      @(negedge clock_in);
      f = ovf ? overflow_flag_out : alarm_flag_out;
      n++;
    end
    chk(ovf ? "overflow_flag" : "alarm_flag", {31'h0, f}, 32'h1);
  endtask : wait_hi

  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  initial begin
    repeat (30000) @(posedge clock_in);
    fails++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge clock_in);
    nrst_in <= 1'b1;
    rd(8'h14, 32'h01);
    @(negedge clock_in);
    chk("invalid_flag", {31'h0, invalid_time_flag_out}, 32'h1);
    rd(8'h18, 32'hFF);
    wr(8'h04, 32'h5);
    rd(8'h04, 32'h0);
    wr(8'h14, 32'hFFFF_FFEF);
    rd(8'h14, 32'h01);
    wr(8'h00, 32'h3);
    rd(8'h14, 32'h00);
    repeat (40) @(posedge clock_in);
    rd(8'h04, 32'h5);
    rd(8'h00, 32'h3);
    $display("test reset_hold done");
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h4);
    wr(8'h14, 32'h10);
    wr(8'h00, 32'h64);
    wait_hi(1'b0);
    wr(8'h14, 32'h0);
    rd(8'h00, 32'h5);
    wr(8'h08, 32'h0);
    rd(8'h14, 32'h0);
    $display("test count_alarm done");
    wr(8'h04, 32'h0);
    wr(8'h00, 32'hFFFF_FFFF);
    wr(8'h14, 32'h10);
    wait_hi(1'b1);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    wr(8'h00, 32'h7);
    rd(8'h14, 32'h12);
    wr(8'h14, 32'h0);
    wr(8'h00, 32'h7);
    rd(8'h14, 32'h0);
    rd(8'h00, 32'h7);
    $display("test overflow done");
    wr(8'h0C, 32'h55);
    avs_byteenable_in <= 4'h2;
    wr(8'h0C, 32'h0000_33AA);
    avs_byteenable_in <= 4'hF;
    rd(8'h0C, 32'h0000_3355);
    wr(8'h18, 32'hF7);
    wr(8'h0C, 32'hAA);
    rd(8'h0C, 32'h0000_3355);
    wr(8'h18, 32'hD7);
    wr(8'h14, 32'h10);
    rd(8'h14, 32'h0);
    wr(8'h10, 32'h08);
    wr(8'h14, 32'h10);
    rd(8'h14, 32'h10);
    wr(8'h14, 32'h0);
    rd(8'h14, 32'h10);
    wr(8'h18, 32'h97);
    wr(8'h18, 32'h87);
    rd(8'h18, 32'h97);
    $display("test locks done");
    wr(8'h10, 32'h01);
    rd(8'h14, 32'h01);
    rd(8'h18, 32'hFF);
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'h01);
    wr(8'h18, 32'hEF);
    rd(8'h18, 32'hEF);
    wr(8'h10, 32'h0);
    rd(8'h10, 32'h01);
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0);
    @(posedge clock_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    nrst_in <= 1'b1;
    rd(8'h18, 32'hFF);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h01);
    $display("test soft_and_por_reset done");
    stop_test();
  end
endmodule : test_rtcsl_status_lock
